// ### pm_defines.svh
/*
 * register offsets, field positions, reset values and timing counts
 * for the power mode and clock manager; assumes a 125 MHz SYS_CLK
 */
`ifndef PM_DEFINES_SVH
`define PM_DEFINES_SVH
// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define A_CTRL 8'h00
`define A_STAT 8'h04
`define A_PRIO 8'h08
`define A_EXC 8'h0c
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define CTRL_W 12
`define CTRL_RST 12'h000
`define PRIO_RST 8'h00
`define FREQ_32M 2'h0
`define FREQ_4M 2'h3
`define PRI_RESET 3'h5
`define PRI_NMI 3'h6
`define PRI_FAULT 3'h7
`define EXC_RESET 3'h0
`define EXC_NMI 3'h1
`define EXC_FAULT 3'h2
`define EXC_IRQ0 3'h4
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_NS 8
`define RST_HOLD_NS 64
`define RST_HOLD_CYC ((`RST_HOLD_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ### pm_pkg.sv
/*
 * types shared by the power mode and clock manager;
 * assumes pm_defines.svh for the numbers
 */
package pm_pkg;
  // operating modes, highest power first
  typedef enum logic [2:0] {
    M_RUN, M_SLEEP, M_STOP, M_STANDBY, M_SHUTDOWN
  } pm_mode_t;
  // software power policy, same layout as the control register
  typedef struct packed {
    logic [1:0] run_lvl;  // run policy level
    logic [2:0] pdiv;     // doubled pll clock divider
    logic [1:0] lvl;      // low-power policy level
    pm_mode_t   mode;     // mode entered on wait
    logic [1:0] freq;     // oscillator frequency select
  } policy_t;
  // clock gates and power switches
  typedef struct packed {
    logic       cpu_clk;
    logic       main_clk;
    logic       main_lim32k;
    logic       osc_en;
    logic [1:0] osc_sel;
    logic       ulp_clk;
    logic       ulp_lim32k;
    logic       lf_clk;
    logic       timg_only;
    logic       rtc_clk;
    logic       bod_en;
    logic       core_reg;
    logic       hp_pwr;
    logic       lp_pwr;
    logic       bus_hp_main;
    logic       bus_lp_ulp;
  } clk_ctl_t;
endpackage : pm_pkg

// ### power_mode_clock_manager.sv
/*
 * power mode and clock manager: mode machine, clock gating,
 * reset chain, exception arbiter and AXI4-Lite register slave.
 * assumes one 125 MHz clock and inputs synchronous to it.
 */
// Function
// R1 - oscillator selectable at 32, 24, 16, 4 MHz
// R2 - doubled pll clock with divider
// R3 - bus clock follows domain: ulp or main
// R4 - five modes run sleep stop standby shutdown
// R5 - cpu runs only in run; interrupts wake
// R6 - shutdown: regulator off, wake pin debug io
// R7 - high-perf domain powered in run, sleep only; the code also powers it in stop and standby during a fast request
// R8 - low-power domain off only in shutdown
// R9 - run levels: full, 32k limit, oscillator off
// R10 - sleep levels equal run, cpu gated
// R11 - stop levels: domain off, 4MHz, ulp 32k
// R12 - standby 0: brownout, all low-power peripherals clocked
// R13 - standby 1: only timers zero, one clocked
// R14 - shutdown no clocks; exit gives brownout reset
// R15 - fast clock request raises clocking temporarily
// R16 - wait instruction enters the policy mode
// R17 - lower priority value wins
// R18 - reset, nmi, fault fixed negative priorities
// R19 - four programmable peripheral priority levels
// R20 - reset levels chain downward before run
// R21 - reset selects run level zero policy
`timescale 1ns/1ns
`include "pm_defines.svh"

module power_mode_clock_manager (
  input  wire logic             SYS_CLK,       // system clock
  input  wire logic             RST_N,         // power-on reset
  input  wire logic [7:0]       AXI_AWADDR,    // write address
  input  wire logic             AXI_AWVALID,   // write address valid
  output logic                  AXI_AWREADY,   // write address ready
  input  wire logic [31:0]      AXI_WDATA,     // write data
  input  wire logic [3:0]       AXI_WSTRB,     // byte strobes
  input  wire logic             AXI_WVALID,    // write data valid
  output logic                  AXI_WREADY,    // write data ready
  output logic [1:0]            AXI_BRESP,     // write response
  output logic                  AXI_BVALID,    // response valid
  input  wire logic             AXI_BREADY,    // response ready
  input  wire logic [7:0]       AXI_ARADDR,    // read address
  input  wire logic             AXI_ARVALID,   // read address valid
  output logic                  AXI_ARREADY,   // read address ready
  output logic [31:0]           AXI_RDATA,     // read data
  output logic [1:0]            AXI_RRESP,     // read response
  output logic                  AXI_RVALID,    // read data valid
  input  wire logic             AXI_RREADY,    // read data ready
  input  wire logic             WAIT_INSTR,    // cpu wait pulse
  input  wire logic             WAKE_IRQ,      // peripheral wake
  input  wire logic             FAST_REQ,      // fast clock request
  input  wire logic             EXT_RESET_PIN, // external reset pin
  input  wire logic             DEBUG_ACT,     // serial-wire debug
  input  wire logic             IO_MATCH,      // wake io match
  input  wire logic             NMI_REQ,       // non-maskable irq
  input  wire logic             FAULT_REQ,     // hard fault
  input  wire logic [3:0]       IRQ_REQ,       // peripheral irqs
  output pm_pkg::clk_ctl_t      CLK_CTL,       // gates and switches
  output pm_pkg::pm_mode_t      MODE,          // current mode
  output logic [2:0]            PLL2X_DIV,     // pll divider
  output logic [3:0]            RESET_LEVELS,  // bod boot sys cpu
  output logic                  EXC_VALID,     // exception pending
  output logic [2:0]            EXC_ID         // winning exception
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  pm_pkg::policy_t  pol_q;     // software policy
  logic [7:0]       prio_q;    // two bits per irq
  pm_pkg::pm_mode_t mode_q;    // mode machine
  logic             fast_q;    // fast request active
  pm_pkg::clk_ctl_t clk_d;     // next gate pattern
  pm_pkg::clk_ctl_t clk_q;     // registered gates
  logic [3:0]       rst_q;     // active reset levels
  logic [3:0]       cnt_q;     // reset hold counter
  logic             trig_bod;  // shutdown exit
  logic             trig_sys;  // pin reset in service
  logic             exc_v_d;   // arbiter result
  logic [2:0]       exc_id_d;  // arbiter winner
  logic             exc_v_q;   // registered valid
  logic [2:0]       exc_id_q;  // registered winner
  logic [2:0]       ipri [4];  // irq priority values

  // axi state
  logic        aw_q, w_q;           // halves captured
  logic        awr_q, wr_q, arr_q;  // ready flops
  logic        bv_q, rv_q;          // answer valid
  logic [1:0]  bresp_q, rresp_q;    // responses
  logic [7:0]  awaddr_q;            // held address
  logic [31:0] wdata_q, rdata_q;    // held data
  logic [3:0]  wstrb_q;             // held strobes
  logic        do_wr;               // commit write
  logic [31:0] mask;                // strobe mask

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // byte strobes to bit mask
  function automatic logic [31:0] bmask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : bmask

  // signed priority compare, lower value wins
  function automatic logic beats(input logic [2:0] a,
                                 input logic [2:0] b);
    return $signed(a) < $signed(b);  // [R17]
  endfunction : beats

  // ----------------------------------------
  // axi write channel
  // ----------------------------------------
  assign do_wr = aw_q && w_q && !bv_q;
  assign mask  = bmask(wstrb_q);

  // address and data captured in either order
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awr_q    <= 1'b1;
      wr_q     <= 1'b1;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else begin
      if (AXI_AWVALID && awr_q) begin
        aw_q     <= 1'b1;
        awr_q    <= 1'b0;
        awaddr_q <= AXI_AWADDR;
      end else if (do_wr) begin
        aw_q <= 1'b0;
      end
      if (AXI_WVALID && wr_q) begin
        w_q     <= 1'b1;
        wr_q    <= 1'b0;
        wdata_q <= AXI_WDATA;
        wstrb_q <= AXI_WSTRB;
      end else if (do_wr) begin
        w_q <= 1'b0;
      end
      // reopen both only once the response is gone
      if (bv_q && AXI_BREADY) begin
        awr_q <= 1'b1;
        wr_q  <= 1'b1;
      end
    end
  end

  // write response, error on unmapped address
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bv_q    <= 1'b0;
      bresp_q <= `RESP_OK;
    end else if (do_wr) begin
      bv_q <= 1'b1;
      case (awaddr_q)
        `A_CTRL, `A_STAT, `A_PRIO, `A_EXC: bresp_q <= `RESP_OK;
        default:                           bresp_q <= `RESP_ERR;
      endcase
    end else if (AXI_BREADY) begin
      bv_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  // policy falls back to run level zero on system reset
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pol_q <= pm_pkg::policy_t'(`CTRL_RST);
    end else if (rst_q[1]) begin
      pol_q <= pm_pkg::policy_t'(`CTRL_RST);  // [R21] [R20]
    end else if (do_wr && awaddr_q == `A_CTRL) begin
      // freq selects 32/24/16/4 MHz, pdiv divides pll x2
      pol_q <= pm_pkg::policy_t'((wdata_q[`CTRL_W-1:0] & mask[`CTRL_W-1:0])
             | (pol_q & ~mask[`CTRL_W-1:0]));  // [R1] [R2]
    end
  end

  // peripheral priority levels, 0 to 3
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      prio_q <= `PRIO_RST;
    end else if (do_wr && awaddr_q == `A_PRIO) begin
      prio_q <= (prio_q & ~mask[7:0]) | (wdata_q[7:0] & mask[7:0]);  // [R19]
    end
  end

  // ----------------------------------------
  // axi read channel
  // ----------------------------------------
  // one read at a time, data one cycle after address
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      arr_q   <= 1'b1;
      rv_q    <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OK;
    end else if (AXI_ARVALID && arr_q) begin
      arr_q   <= 1'b0;
      rv_q    <= 1'b1;
      rresp_q <= `RESP_OK;
      case (AXI_ARADDR)
        `A_CTRL: rdata_q <= {20'h00000, pol_q};
        `A_STAT: rdata_q <= {22'h000000, clk_q.hp_pwr, clk_q.lp_pwr,
                             fast_q, rst_q, mode_q};
        `A_PRIO: rdata_q <= {24'h000000, prio_q};
        `A_EXC:  rdata_q <= {28'h0000000, exc_v_q, exc_id_q};
        default: begin
          rdata_q <= 32'h0000_0000;  // unmapped reads zero
          rresp_q <= `RESP_ERR;
        end
      endcase
    end else if (rv_q && AXI_RREADY) begin
      rv_q  <= 1'b0;
      arr_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // reset chain
  // ----------------------------------------
  // leaving shutdown is a brownout level reset
  assign trig_bod = mode_q == pm_pkg::M_SHUTDOWN
                 && (EXT_RESET_PIN || DEBUG_ACT || IO_MATCH);  // [R6] [R14]
  assign trig_sys = mode_q != pm_pkg::M_SHUTDOWN && EXT_RESET_PIN;

  // a level also asserts every level below it
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_q <= 4'hf;
      cnt_q <= 4'(`RST_HOLD_CYC);
    end else if (trig_bod) begin
      rst_q <= 4'hf;  // [R20]
      cnt_q <= 4'(`RST_HOLD_CYC);
    end else if (trig_sys) begin
      rst_q <= rst_q | 4'h3;  // [R20]
      cnt_q <= 4'(`RST_HOLD_CYC);
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else begin
      rst_q <= 4'h0;
    end
  end

  // ----------------------------------------
  // mode machine
  // ----------------------------------------
  // code runs only in run; any system reset lands in run
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_q <= pm_pkg::M_RUN;
    end else if (rst_q[1] || trig_sys) begin
      mode_q <= pm_pkg::M_RUN;  // [R20]
    end else begin
      case (mode_q)  // [R4]
        pm_pkg::M_RUN: begin
          if (WAIT_INSTR) begin
            mode_q <= pol_q.mode;  // [R16]
          end
        end
        pm_pkg::M_SLEEP, pm_pkg::M_STOP, pm_pkg::M_STANDBY: begin
          if (WAKE_IRQ) begin
            mode_q <= pm_pkg::M_RUN;  // [R5]
          end
        end
        pm_pkg::M_SHUTDOWN: begin
          mode_q <= pm_pkg::M_SHUTDOWN;  // left via reset only
        end
        default: begin
          mode_q <= pm_pkg::M_RUN;  // bad policy code
        end
      endcase
    end
  end

  // fast request serviced in sleep, stop and standby
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      fast_q <= 1'b0;
    end else begin
      fast_q <= FAST_REQ && (mode_q == pm_pkg::M_SLEEP
             || mode_q == pm_pkg::M_STOP
             || mode_q == pm_pkg::M_STANDBY);  // [R15]
    end
  end

  // ----------------------------------------
  // clock and power pattern
  // ----------------------------------------
  always_comb begin
    pm_pkg::pm_mode_t em;
    logic [1:0]       el;
    em    = mode_q;
    el    = (mode_q == pm_pkg::M_RUN) ? pol_q.run_lvl : pol_q.lvl;
    clk_d = '0;
    // fast request borrows sleep level zero for the moment
    if (fast_q) begin
      el = 2'h0;  // [R15]
      if (mode_q != pm_pkg::M_SLEEP) begin
        em = pm_pkg::M_SLEEP;
      end
    end
    clk_d.core_reg = 1'b1;
    clk_d.lp_pwr   = 1'b1;  // [R8]
    clk_d.ulp_clk  = 1'b1;
    clk_d.lf_clk   = 1'b1;
    clk_d.rtc_clk  = 1'b1;
    clk_d.bod_en   = 1'b1;
    case (em)
      pm_pkg::M_RUN, pm_pkg::M_SLEEP: begin
        clk_d.cpu_clk     = em == pm_pkg::M_RUN;  // [R5] [R10]
        clk_d.main_clk    = 1'b1;
        clk_d.hp_pwr      = 1'b1;  // [R7]
        clk_d.main_lim32k = el != 2'h0;  // [R9]
        clk_d.osc_en      = el != 2'h2;  // [R9]
        clk_d.osc_sel     = pol_q.freq;  // [R1]
      end
      pm_pkg::M_STOP: begin
        // main domain unpowered, oscillator geared per level
        clk_d.main_lim32k = el != 2'h0;
        clk_d.osc_en      = el != 2'h2;  // [R11]
        clk_d.osc_sel     = (el == 2'h1) ? `FREQ_4M : pol_q.freq;  // [R11]
        clk_d.ulp_lim32k  = el == 2'h2;  // [R11]
      end
      pm_pkg::M_STANDBY: begin
        clk_d.ulp_lim32k = 1'b1;  // [R12]
        clk_d.timg_only  = el != 2'h0;  // [R13]
      end
      default: begin
        clk_d = '0;  // shutdown: nothing runs [R14] [R6] [R8]
      end
    endcase
    clk_d.bus_hp_main = clk_d.main_clk;  // [R3]
    clk_d.bus_lp_ulp  = clk_d.ulp_clk;   // [R3]
  end

  // registered so every gate is glitch free
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      clk_q <= '0;
    end else begin
      clk_q <= clk_d;
    end
  end

  // ----------------------------------------
  // exception arbiter
  // ----------------------------------------
  generate
    for (genvar i = 0; i < 4; i++) begin : g_pri
      assign ipri[i] = {1'b0, prio_q[2*i+1 -: 2]};  // [R19]
    end
  endgenerate

  // fixed negatives beat every peripheral, ties to lower id
  always_comb begin
    logic [2:0] best;
    best     = 3'h3;
    exc_v_d  = 1'b0;
    exc_id_d = `EXC_RESET;
    if (rst_q[0]) begin
      exc_v_d = 1'b1;
      best    = `PRI_RESET;  // [R18]
    end else if (NMI_REQ) begin
      exc_v_d  = 1'b1;
      exc_id_d = `EXC_NMI;
      best     = `PRI_NMI;  // [R18]
    end else if (FAULT_REQ) begin
      exc_v_d  = 1'b1;
      exc_id_d = `EXC_FAULT;
      best     = `PRI_FAULT;  // [R18]
    end
    for (int i = 0; i < 4; i++) begin
      if (IRQ_REQ[i] && (!exc_v_d || beats(ipri[i], best))) begin
        exc_v_d  = 1'b1;
        exc_id_d = `EXC_IRQ0 + 3'(i);  // [R17]
        best     = ipri[i];
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      exc_v_q  <= 1'b0;
      exc_id_q <= `EXC_RESET;
    end else begin
      exc_v_q  <= exc_v_d;
      exc_id_q <= exc_id_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign AXI_AWREADY  = awr_q;
  assign AXI_WREADY   = wr_q;
  assign AXI_BVALID   = bv_q;
  assign AXI_BRESP    = bresp_q;
  assign AXI_ARREADY  = arr_q;
  assign AXI_RVALID   = rv_q;
  assign AXI_RDATA    = rdata_q;
  assign AXI_RRESP    = rresp_q;
  assign CLK_CTL      = clk_q;
  assign MODE         = mode_q;
  assign PLL2X_DIV    = pol_q.pdiv;
  assign RESET_LEVELS = rst_q;
  assign EXC_VALID    = exc_v_q;
  assign EXC_ID       = exc_id_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  cpu_run_only_a: assert property (  // [R5]
    clk_q.cpu_clk |-> $past(mode_q) == pm_pkg::M_RUN && !$past(fast_q))
    else $error("cpu clock outside run");
  wake_to_run_a: assert property (  // [R5]
    mode_q inside {pm_pkg::M_SLEEP, pm_pkg::M_STOP, pm_pkg::M_STANDBY}
    && WAKE_IRQ && !rst_q[1] && !trig_sys |=> mode_q == pm_pkg::M_RUN)
    else $error("wake did not return to run");
  wait_entry_a: assert property (  // [R16]
    mode_q == pm_pkg::M_RUN && WAIT_INSTR && !rst_q[1] && !trig_sys
    |=> mode_q == $past(pol_q.mode) || mode_q == pm_pkg::M_RUN)
    else $error("wait entered wrong mode");
  hp_domain_a: assert property (  // [R7]
    clk_q.hp_pwr |-> $past(mode_q) inside {pm_pkg::M_RUN, pm_pkg::M_SLEEP}
    || $past(fast_q))
    else $error("high-perf domain powered in low mode");
  shutdown_off_a: assert property (  // [R14]
    $past(mode_q) == pm_pkg::M_SHUTDOWN |-> !clk_q.lp_pwr && !clk_q.hp_pwr
    && !clk_q.core_reg && !clk_q.bod_en && !clk_q.rtc_clk)
    else $error("shutdown left something running");
  run_level_a: assert property (  // [R9]
    mode_q == pm_pkg::M_RUN && pol_q.run_lvl == 2'h2 && !fast_q
    |=> clk_q.main_lim32k && !clk_q.osc_en)
    else $error("run level two pattern wrong");
  stop_gear_a: assert property (  // [R11]
    mode_q == pm_pkg::M_STOP && pol_q.lvl == 2'h1 && !fast_q
    |=> clk_q.osc_sel == `FREQ_4M && !clk_q.main_clk)
    else $error("stop level one not at 4MHz");
  sys_chain_a: assert property (  // [R20]
    trig_sys |=> rst_q[1:0] == 2'h3 [*8])
    else $error("reset chain released early");
  default_pol_a: assert property (  // [R21]
    $fell(rst_q[1]) |-> pol_q.run_lvl == 2'h0 && pol_q.mode == pm_pkg::M_RUN)
    else $error("policy not run level zero");
  nmi_first_a: assert property (  // [R18]
    NMI_REQ && !rst_q[0] |=> EXC_VALID && EXC_ID == `EXC_NMI)
    else $error("nmi lost arbitration");

  sleep_cov: cover property (
    mode_q == pm_pkg::M_RUN ##1 mode_q == pm_pkg::M_SLEEP ##[1:20]
    mode_q == pm_pkg::M_RUN);
  fast_cov: cover property (mode_q == pm_pkg::M_STANDBY && fast_q);
  shutdown_cov: cover property (mode_q == pm_pkg::M_SHUTDOWN ##1 rst_q[3]);

endmodule : power_mode_clock_manager

// ### pm_far_side.sv
/*
 * far-side model: cpu wait pulses, peripheral wake, fast requests,
 * shutdown wake sources and exception sources.
 * assumes the bench calls its tasks from one process at a time.
 */
`timescale 1ns/1ns
module pm_far_side (
  input  wire logic       clk,   // system clock
  output logic [5:0]      ev,    // io, debug, pin, fast, wake, wait
  output logic [3:0]      irq,   // peripheral irq levels
  output logic            nmi,   // non-maskable request
  output logic            flt    // hard fault request
);
  // ----------------------------------------
  // idle levels
  // ----------------------------------------
  initial begin
    ev = '0;
    irq = '0;
    nmi = 1'b0;
    flt = 1'b0;
  end
  // one-cycle pulse: wait instr wake pin/debug/io
  task automatic pulse(input int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev[k] <= 1'b0;
  endtask : pulse
  // fast request stays up while the peripheral works
  task automatic hold(input int k, input logic v);
    @(posedge clk);
    ev[k] <= v;
  endtask : hold
  // exception levels, held until changed
  task automatic raise(input logic [3:0] i, input logic n, input logic f);
    @(posedge clk);
    irq <= i;
    nmi <= n;
    flt <= f;
  endtask : raise
endmodule : pm_far_side

// ### power_mode_clock_manager_bench.sv
/*
 * self-checking bench for the power mode and clock manager;
 * assumes pm_defines.svh, pm_pkg and the far-side model.
 */
`timescale 1ns/1ns
`include "pm_defines.svh"
module power_mode_clock_manager_bench;
  logic SYS_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [7:0] AXI_AWADDR = '0, AXI_ARADDR = '0;
  logic [31:0] AXI_WDATA = '0;
  logic [3:0] AXI_WSTRB = '0;
  logic AXI_AWVALID = 1'b0, AXI_WVALID = 1'b0, AXI_BREADY = 1'b0;
  logic AXI_ARVALID = 1'b0, AXI_RREADY = 1'b0;
  logic AXI_AWREADY, AXI_WREADY, AXI_BVALID, AXI_ARREADY, AXI_RVALID, EXC_VALID;
  logic [1:0] AXI_BRESP, AXI_RRESP;
  logic [31:0] AXI_RDATA;
  logic [5:0] ev;                 // far-side event lines
  logic [3:0] irq, RESET_LEVELS;  // irqs, reset chain
  logic nmi, flt;
  logic [2:0] PLL2X_DIV, EXC_ID;
  pm_pkg::clk_ctl_t CLK_CTL;
  pm_pkg::pm_mode_t MODE;
  pm_pkg::policy_t p;             // policy being written
  int fail_count = 0;
  int checked = 0;
  always #4 SYS_CLK = ~SYS_CLK;
  pm_far_side i_far (.clk(SYS_CLK), .ev, .irq, .nmi, .flt);
  power_mode_clock_manager i_dut (.SYS_CLK, .RST_N, .AXI_AWADDR, .AXI_AWVALID, .AXI_AWREADY,
    .AXI_WDATA, .AXI_WSTRB, .AXI_WVALID, .AXI_WREADY, .AXI_BRESP, .AXI_BVALID, .AXI_BREADY,
    .AXI_ARADDR, .AXI_ARVALID, .AXI_ARREADY, .AXI_RDATA, .AXI_RRESP, .AXI_RVALID, .AXI_RREADY,
    .WAIT_INSTR(ev[0]), .WAKE_IRQ(ev[1]), .FAST_REQ(ev[2]), .EXT_RESET_PIN(ev[3]),
    .DEBUG_ACT(ev[4]), .IO_MATCH(ev[5]), .NMI_REQ(nmi), .FAULT_REQ(flt), .IRQ_REQ(irq),
    .CLK_CTL, .MODE, .PLL2X_DIV, .RESET_LEVELS, .EXC_VALID, .EXC_ID);
  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : cmp
  task automatic report_and_stop();
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge SYS_CLK);
    AXI_AWADDR <= a;
    AXI_AWVALID <= 1'b1;
    AXI_WDATA <= d;
    AXI_WSTRB <= 4'hf;
    AXI_WVALID <= 1'b1;
    AXI_BREADY <= 1'b1;
    fork
      begin
        do @(posedge SYS_CLK); while (AXI_AWREADY !== 1'b1);
        AXI_AWVALID <= 1'b0;
      end
      begin
        do @(posedge SYS_CLK); while (AXI_WREADY !== 1'b1);
        AXI_WVALID <= 1'b0;
      end
    join
    while (AXI_BVALID !== 1'b1) @(posedge SYS_CLK);
    cmp("bresp", er, AXI_BRESP);
    AXI_BREADY <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    @(posedge SYS_CLK);
    AXI_ARADDR <= a;
    AXI_ARVALID <= 1'b1;
    AXI_RREADY <= 1'b1;
    do @(posedge SYS_CLK); while (AXI_ARREADY !== 1'b1);
    AXI_ARVALID <= 1'b0;
    while (AXI_RVALID !== 1'b1) @(posedge SYS_CLK);
    cmp("rdata", ex, AXI_RDATA);
    cmp("rresp", er, AXI_RRESP);
    AXI_RREADY <= 1'b0;
  endtask : rd
  // only the gates that the mode and level fix are compared
  task automatic chk_clk(input pm_pkg::pm_mode_t md, input logic [1:0] lv, input logic [1:0] fq);
    pm_pkg::clk_ctl_t e, m;
    e = '0;
    m = '0;
    {m.cpu_clk, m.main_clk, m.hp_pwr, m.lp_pwr, m.core_reg} = 5'h1f;
    e.cpu_clk = (md == pm_pkg::M_RUN);
    e.main_clk = (md <= pm_pkg::M_SLEEP);
    e.hp_pwr = e.main_clk;
    e.lp_pwr = (md != pm_pkg::M_SHUTDOWN);
    e.core_reg = e.lp_pwr;
    if (md <= pm_pkg::M_STOP) begin
      {m.main_lim32k, m.osc_en, m.osc_sel} = 4'hf;
      {e.main_lim32k, e.osc_en, e.osc_sel} = {lv != 2'h0, lv != 2'h2, fq};
    end
    if (md == pm_pkg::M_STOP) begin
      m.ulp_lim32k = 1'b1;
      e.ulp_lim32k = (lv == 2'h2);
      m.main_lim32k = 1'b0;
      if (lv != 2'h1) m.osc_sel = 2'h0;
      else e.osc_sel = `FREQ_4M;
    end
    if (md == pm_pkg::M_STANDBY) begin
      {m.bod_en, m.rtc_clk, m.ulp_clk, m.lf_clk, m.ulp_lim32k, m.timg_only, m.osc_en} = 7'h7f;
      {e.bod_en, e.rtc_clk, e.ulp_clk, e.lf_clk, e.ulp_lim32k, e.timg_only} = {5'h1f, lv[0]};
    end
    if (md == pm_pkg::M_SHUTDOWN) m = '1;
    cmp("clk ctl", e & m, CLK_CTL & m);
  endtask : chk_clk
  // wait for the reset chain to let go, bounded
  task automatic settle();
    for (int n = 0; n < 40 && RESET_LEVELS !== 4'h0; n++) @(posedge SYS_CLK);
    cmp("levels", 32'h0, RESET_LEVELS);
  endtask : settle
  task automatic arb(input logic [3:0] i, input logic n, input logic f, input logic [2:0] ex);
    i_far.raise(i, n, f);
    repeat (3) @(posedge SYS_CLK);
    cmp("exc id", ex, EXC_ID);
    cmp("exc valid", 32'h1, EXC_VALID);
    rd(`A_EXC, {28'h0, 1'b1, ex}, `RESP_OK);
  endtask : arb
  // ----------------------------------------
  // watchdog and main sequence
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge SYS_CLK);
    cmp("levels", 32'hf, RESET_LEVELS);
    RST_N <= 1'b1;
    settle();
    cmp("mode", pm_pkg::M_RUN, MODE);
    rd(`A_CTRL, 32'h0, `RESP_OK);
    chk_clk(pm_pkg::M_RUN, 2'h0, 2'h0);
    cmp("bus src", 32'h3, {CLK_CTL.bus_hp_main, CLK_CTL.bus_lp_ulp});
    rd(`A_STAT, 32'h300, `RESP_OK);
    wr(8'h10, 32'h1, `RESP_ERR);
    rd(8'h10, 32'h0, `RESP_ERR);
    // run levels with every oscillator frequency and the odd dividers 1, 3, 5, 7
    for (int i = 0; i < 4; i++) begin
      p = '{2'(i), 3'(2 * i + 1), 2'h0, pm_pkg::M_RUN, 2'(i)};
      wr(`A_CTRL, {20'h0, p}, `RESP_OK);
      repeat (4) @(posedge SYS_CLK);
      chk_clk(pm_pkg::M_RUN, 2'(i), 2'(i));
      cmp("pll div", 2 * i + 1, PLL2X_DIV);
      rd(`A_CTRL, {20'h0, p}, `RESP_OK);
    end
    // sleep, stop and standby at each level, fast request, then wake
    for (int md = 1; md < 4; md++) begin
      for (int lv = 0; lv < 3; lv++) begin
        if (md == 3 && lv == 2) continue;
        p = '{2'h0, 3'h0, 2'(lv), pm_pkg::pm_mode_t'(md), 2'h2};
        wr(`A_CTRL, {20'h0, p}, `RESP_OK);
        i_far.pulse(0);
        repeat (4) @(posedge SYS_CLK);
        cmp("mode", md, MODE);
        chk_clk(pm_pkg::pm_mode_t'(md), 2'(lv), 2'h2);
        i_far.hold(2, 1'b1);
        repeat (4) @(posedge SYS_CLK);
        chk_clk(pm_pkg::M_SLEEP, 2'h0, 2'h2);
        i_far.hold(2, 1'b0);
        i_far.pulse(1);
        repeat (4) @(posedge SYS_CLK);
        cmp("mode", pm_pkg::M_RUN, MODE);
        chk_clk(pm_pkg::M_RUN, 2'h0, 2'h2);
      end
    end
    // shutdown left only through the reset chain
    for (int k = 3; k < 6; k++) begin
      p = '{2'h0, 3'h0, 2'h0, pm_pkg::M_SHUTDOWN, 2'h0};
      wr(`A_CTRL, {20'h0, p}, `RESP_OK);
      i_far.pulse(0);
      repeat (4) @(posedge SYS_CLK);
      chk_clk(pm_pkg::M_SHUTDOWN, 2'h0, 2'h0);
      i_far.pulse(1);
      repeat (4) @(posedge SYS_CLK);
      cmp("mode", pm_pkg::M_SHUTDOWN, MODE);
      i_far.pulse(k);
      repeat (2) @(posedge SYS_CLK);
      cmp("levels", 32'hf, RESET_LEVELS);
      settle();
      rd(`A_CTRL, 32'h0, `RESP_OK);
    end
    i_far.pulse(3);
    repeat (2) @(posedge SYS_CLK);
    cmp("levels", 32'h3, RESET_LEVELS);
    settle();
    // exception arbitration
    wr(`A_PRIO, 32'h1b, `RESP_OK);
    arb(4'h7, 1'b0, 1'b0, 3'h6);
    arb(4'hf, 1'b0, 1'b0, 3'h7);
    arb(4'hf, 1'b0, 1'b1, `EXC_FAULT);
    arb(4'hf, 1'b1, 1'b1, `EXC_NMI);
    wr(`A_PRIO, 32'h0, `RESP_OK);
    arb(4'h6, 1'b0, 1'b0, 3'h5);
    report_and_stop();
  end
endmodule : power_mode_clock_manager_bench
